/* chrf_framer.sv */
// Function
// - Type byte bit 7 is one when at least one extension block follows the header, else zero.
// - Type byte bits 6:0 carry the value 20 for this colored hash record.
// - Layout follows the plain Ethernet record, with the loss counter field holding the tag.
// - A 2-byte hardware tag reports the classification outcome for the frame.
// - The tag holds the hash in bits 0 to 3 and the class color from bit 4 upward.
// - A 1-byte offset field is emitted but not implemented, so its value is meaningless.
// - A 1-byte pad follows the offset and the frame starts right after it.
// - Payload length equals record length minus 16, minus extension blocks, minus 2.
// - Extension presence is flagged by the type byte top bit regardless of record type.
// - Each extension block starts with a type byte whose bit 7 is set only if another follows.
// - Each extension block is exactly 8 bytes long.
module chrf_framer
  import chrf_pkg::*;
#(
  parameter int EXT_N   = EXT_MAX,
  parameter int LEN_W   = 16
)(
  input  wire logic                      clk_sys_i,
  input  wire logic                      reset_n_i,
  input  wire logic                      start_i,
  input  wire logic [TS_BYTES*8-1:0]     timestamp_i,
  input  wire logic [7:0]                flags_i,
  input  wire logic [LEN_W-1:0]          wire_len_i,
  input  wire logic [LEN_W-1:0]          cap_len_i,
  input  wire logic [HASH_W-1:0]         hash_i,
  input  wire logic [CLASS_W-1:0]        filter_class_tag_i,
  input  wire logic [$clog2(EXT_N+1)-1:0] ext_count_i,
  input  wire logic [EXT_N*64-1:0]       ext_data_i,
  output logic                           busy_o,
  output logic                           pay_ready_o,
  input  wire logic                      pay_valid_i,
  input  wire logic [7:0]                pay_data_i,
  output logic                           out_valid_o,
  output logic [7:0]                     out_data_o,
  output logic                           out_last_o,
  input  wire logic                      out_ready_i
);
  localparam int CW = $clog2(EXT_N+1);

  chrf_state_t           state_r, state_nxt;
  logic [LEN_W-1:0]      idx_r;
  logic [CW-1:0]         ext_idx_r;
  logic [2:0]            ext_byte_r;
  logic [1:0]            tail_idx_r;
  logic [TS_BYTES*8-1:0] ts_r;
  logic [7:0]            flags_r;
  logic [LEN_W-1:0]      wlen_r;
  logic [LEN_W-1:0]      clen_r;
  logic [LEN_W-1:0]      rlen_r;
  logic [15:0]           tag_r;
  logic [CW-1:0]         ext_cnt_r;
  logic [EXT_N*64-1:0]   ext_r;
  logic [7:0]            out_data_r;
  logic                  out_valid_r;
  logic                  out_last_r;

  wire logic [LEN_W-1:0] ext_total_w = LEN_W'(ext_count_i) * LEN_W'(EXT_BYTES);
  // Record length is built forward from the capture length plus header, extension and trailer bytes
  wire logic [LEN_W-1:0] rlen_w = cap_len_i + LEN_W'(HDR_BYTES) + ext_total_w
                                  + LEN_W'(PROTO_BYTES);
  wire logic             ext_any_w = (ext_cnt_r != '0);
  wire logic [7:0]       type_w = {ext_any_w, REC_TYPE_CODE};
  wire logic             adv_w = !out_valid_r || out_ready_i;
  wire logic             more_ext_w = (CW'(ext_idx_r + 1'b1) < ext_cnt_r);

  // Header bytes: timestamp, type, flags, record length, tag, wire length
  logic [7:0] hdr_byte_w;
  always_comb
  begin
    hdr_byte_w = 8'h00;
    if (idx_r < LEN_W'(TS_BYTES))
      hdr_byte_w = ts_r[8*(TS_BYTES-1-32'(idx_r[3:0]))+:8];
    else if (idx_r == LEN_W'(8))
      hdr_byte_w = type_w;
    else if (idx_r == LEN_W'(9))
      hdr_byte_w = flags_r;
    else if (idx_r == LEN_W'(10))
      hdr_byte_w = rlen_r[15:8];
    else if (idx_r == LEN_W'(11))
      hdr_byte_w = rlen_r[7:0];
    else if (idx_r == LEN_W'(12))
      hdr_byte_w = tag_r[15:8]; // Loss counter slot holds the tag
    else if (idx_r == LEN_W'(13))
      hdr_byte_w = tag_r[7:0];
    else if (idx_r == LEN_W'(14))
      hdr_byte_w = wlen_r[15:8];
    else
      hdr_byte_w = wlen_r[7:0];
  end

  // Extension block bytes, first byte carries the continuation flag
  wire logic [63:0] ext_word_w = ext_r[64*32'(ext_idx_r)+:64];
  wire logic [7:0]  ext_raw_w  = ext_word_w[8*(7-32'(ext_byte_r))+:8];
  wire logic [7:0]  ext_byte_w = (ext_byte_r == 3'd0) ?
                                 {more_ext_w, ext_raw_w[6:0]} : ext_raw_w;

  // Trailer: offset, pad, then frame
  wire logic [7:0] tail_byte_w = (tail_idx_r == 2'd0) ? OFFSET_FILL : PAD_FILL;

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:
        if (start_i)
          state_nxt = ST_HDR;
      ST_HDR:
        if (adv_w && idx_r == LEN_W'(HDR_BYTES-1))
          state_nxt = ext_any_w ? ST_EXT : ST_TAIL;
      ST_EXT:
        if (adv_w && ext_byte_r == 3'd7 && !more_ext_w)
          state_nxt = ST_TAIL;
      ST_TAIL:
        if (adv_w && tail_idx_r == 2'd1)
          state_nxt = (clen_r == '0) ? ST_IDLE : ST_PAY;
      ST_PAY:
        if (adv_w && pay_valid_i && idx_r == clen_r - 1'b1)
          state_nxt = ST_IDLE;
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  assign pay_ready_o = (state_r == ST_PAY) && adv_w;
  assign busy_o      = (state_r != ST_IDLE);
  assign out_valid_o = out_valid_r;
  assign out_data_o  = out_data_r;
  assign out_last_o  = out_last_r;

  wire logic emit_w = adv_w && ((state_r == ST_HDR) || (state_r == ST_EXT) ||
                      (state_r == ST_TAIL) || (state_r == ST_PAY && pay_valid_i));
  wire logic [7:0] emit_data_w = (state_r == ST_HDR)  ? hdr_byte_w :
                                 (state_r == ST_EXT)  ? ext_byte_w :
                                 (state_r == ST_TAIL) ? tail_byte_w : pay_data_i;
  wire logic emit_last_w = (state_r == ST_TAIL) ? (tail_idx_r == 2'd1 && clen_r == '0) :
                           (state_r == ST_PAY && idx_r == clen_r - 1'b1);

  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
    begin
      state_r     <= ST_IDLE;
      out_valid_r <= 1'b0;
      out_data_r  <= 8'h00;
      out_last_r  <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      if (adv_w)
      begin
        out_valid_r <= emit_w;
        out_data_r  <= emit_w ? emit_data_w : 8'h00;
        out_last_r  <= emit_w && emit_last_w;
      end
    end
  end

  // Capture descriptor at start; hash low, class color above it
  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i)
    begin
      idx_r      <= '0;
      ext_idx_r  <= '0;
      ext_byte_r <= 3'd0;
      tail_idx_r <= 2'd0;
      ts_r       <= '0;
      flags_r    <= 8'h00;
      wlen_r     <= '0;
      clen_r     <= '0;
      rlen_r     <= '0;
      tag_r      <= 16'h0000;
      ext_cnt_r  <= '0;
      ext_r      <= '0;
    end
    else if (state_r == ST_IDLE && start_i)
    begin
      idx_r      <= '0;
      ext_idx_r  <= '0;
      ext_byte_r <= 3'd0;
      tail_idx_r <= 2'd0;
      ts_r       <= timestamp_i;
      flags_r    <= flags_i;
      wlen_r     <= wire_len_i;
      clen_r     <= cap_len_i;
      rlen_r     <= rlen_w;
      tag_r      <= {filter_class_tag_i, hash_i};
      ext_cnt_r  <= (ext_count_i > CW'(EXT_N)) ? CW'(EXT_N) : ext_count_i;
      ext_r      <= ext_data_i;
    end
    else if (adv_w)
    begin
      case (state_r)
        ST_HDR:
          idx_r <= (idx_r == LEN_W'(HDR_BYTES-1)) ? '0 : idx_r + 1'b1;
        ST_EXT:
        begin
          ext_byte_r <= ext_byte_r + 3'd1;
          if (ext_byte_r == 3'd7)
            ext_idx_r <= ext_idx_r + 1'b1;
        end
        ST_TAIL:
          tail_idx_r <= tail_idx_r + 2'd1;
        ST_PAY:
          if (pay_valid_i)
            idx_r <= idx_r + 1'b1;
        default:
          idx_r <= idx_r;
      endcase
    end
  end
endmodule

/* chrf_pkg.sv */
package chrf_pkg;
  localparam int            HDR_BYTES      = 16;
  localparam int            EXT_BYTES      = 8;
  localparam int            PROTO_BYTES    = 2;
  localparam logic [6:0]    REC_TYPE_CODE  = 7'h14;
  localparam int            EXT_FLAG_BIT   = 7;
  localparam int            HASH_W         = 4;
  localparam int            CLASS_W        = 12;
  localparam logic [7:0]    OFFSET_FILL    = 8'h00;
  localparam logic [7:0]    PAD_FILL       = 8'h00;
  localparam int            TS_BYTES       = 8;
  localparam int            EXT_MAX        = 4;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_HDR  = 3'b001,
    ST_EXT  = 3'b010,
    ST_TAIL = 3'b011,
    ST_PAY  = 3'b100
  } chrf_state_t;
endpackage

/* chrf_framer_properties.sv */
module chrf_framer_properties
  import chrf_pkg::*;
#(parameter int EXT_N = EXT_MAX)
(
  input wire logic                        clk_sys_i,
  input wire logic                        reset_n_i,
  input wire logic                        start_i,
  input wire logic                        busy_o,
  input wire logic                        out_valid_o,
  input wire logic [7:0]                  out_data_o,
  input wire logic                        out_last_o,
  input wire logic                        out_ready_i,
  input wire logic [$clog2(EXT_N+1)-1:0]  ext_count_i
);
  logic [7:0] k_r;
  logic [3:0] n_r;
  wire        ext_head = out_valid_o && k_r >= 16 && k_r < 16 + 8 * n_r && k_r[2:0] == 3'h0;
  // Byte index inside the record, cleared after the final byte is taken
  always_ff @(posedge clk_sys_i)
  begin
    if (!reset_n_i || (out_valid_o && out_ready_i && out_last_o))
      k_r <= 8'h00;
    else if (out_valid_o && out_ready_i)
      k_r <= k_r + 8'h01;
    if (start_i && !busy_o)
      n_r <= 4'(ext_count_i);
  end
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_launch;
    busy_o ##1 out_valid_o;
  endsequence
  a_start_answer: assert property (start_i && !busy_o |=> s_launch)
    else $error("record did not start on time");
  a_busy_cause: assert property ($rose(busy_o) |-> $past(start_i))
    else $error("busy rose without start");
  a_out_hold: assert property (out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_data_o) && $stable(out_last_o))
    else $error("output byte changed while stalled");
  a_type_code: assert property (out_valid_o && k_r == 8 |-> out_data_o[6:0] == REC_TYPE_CODE)
    else $error("wrong record type code");
  a_ext_flag: assert property (out_valid_o && k_r == 8 |-> out_data_o[7] == (n_r != 0))
    else $error("wrong extension present flag");
  a_ext_chain: assert property (ext_head |-> out_data_o[7] == (k_r + 8 < 16 + 8 * n_r))
    else $error("wrong continuation flag");
  a_pad_fill: assert property (out_valid_o && k_r == 17 + 8 * n_r |-> out_data_o == PAD_FILL)
    else $error("pad byte not zero");
  a_last_idle: assert property (out_valid_o && out_last_o |-> !busy_o && k_r >= 17 + 8 * n_r)
    else $error("last byte misplaced");
endmodule
bind chrf_framer chrf_framer_properties #(.EXT_N(EXT_N)) u_props (.clk_sys_i(clk_sys_i),
  .reset_n_i(reset_n_i), .start_i(start_i), .busy_o(busy_o), .out_valid_o(out_valid_o),
  .out_data_o(out_data_o), .out_last_o(out_last_o), .out_ready_i(out_ready_i),
  .ext_count_i(ext_count_i));

/* chrf_host_sink.sv */
module chrf_host_sink
(
  input  wire logic       clk_sys_i,
  input  wire logic       out_valid_i,
  input  wire logic [7:0] out_data_i,
  input  wire logic       out_last_i,
  output logic            out_ready_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] q[$];
  int         t = 0;
  initial out_ready_o = 1'b0;
  // Stalls one cycle in three, as a briefly full host ring would
  always @(posedge clk_sys_i)
  begin
    if (out_valid_i && out_ready_o)
      q.push_back({out_last_i, out_data_i});
    t = t + 1;
    out_ready_o <= #1 (t % 3 != 0);
  end
endmodule

/* testbench.sv */
module testbench;
  import chrf_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic         clk_sys_i, reset_n_i, start_i, busy_o, pay_ready_o, out_valid_o, out_last_o;
  logic         out_ready_i;
  logic [63:0]  timestamp_i = 64'h0102030405060708;
  logic [7:0]   flags_i = 8'h5a, pay_data_i = 8'ha0, out_data_o;
  logic [15:0]  wire_len_i = 16'h0040, cap_len_i;
  logic [3:0]   hash_i;
  logic [11:0]  filter_class_tag_i;
  logic [2:0]   ext_count_i;
  logic [255:0] ext_data_i = {8{32'h1a5b3c7d}};
  logic [8:0]   exp_q[$];
  int           err_total = 0;
  int           n_compared = 0;
  chrf_framer DUT (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .start_i(start_i),
    .timestamp_i(timestamp_i), .flags_i(flags_i), .wire_len_i(wire_len_i),
    .cap_len_i(cap_len_i), .hash_i(hash_i), .filter_class_tag_i(filter_class_tag_i),
    .ext_count_i(ext_count_i), .ext_data_i(ext_data_i), .busy_o(busy_o),
    .pay_ready_o(pay_ready_o), .pay_valid_i(1'b1), .pay_data_i(pay_data_i),
    .out_valid_o(out_valid_o), .out_data_o(out_data_o), .out_last_o(out_last_o),
    .out_ready_i(out_ready_i));
  chrf_host_sink sink (.clk_sys_i(clk_sys_i), .out_valid_i(out_valid_o),
    .out_data_i(out_data_o), .out_last_i(out_last_o), .out_ready_o(out_ready_i));
  initial
  begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i)
    if (pay_ready_o)
      pay_data_i <= #1 pay_data_i + 8'h01;
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task stop_test;
    $display("compared %0d mismatched %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic run_rec(input int n, input logic [15:0] cl, input logic [3:0] h,
                         input logic [11:0] c);
    logic [15:0] rl;
    logic [7:0]  b;
    logic [47:0] mid;
    int          w;
    rl = cl + 16'd18 + 16'(8 * n);
    exp_q = {};
    sink.q = {};
    for (int i = 0; i < 8; i++)
      exp_q.push_back({1'b0, timestamp_i[63-8*i -: 8]});
    exp_q.push_back({1'b0, n != 0, REC_TYPE_CODE});
    exp_q.push_back({1'b0, flags_i});
    mid = {rl, c, h, wire_len_i};
    for (int i = 0; i < 6; i++)
      exp_q.push_back({1'b0, mid[47-8*i -: 8]});
    for (int i = 0; i < 8 * n; i++)
    begin
      b = ext_data_i[64*(i/8)+63-8*(i%8) -: 8];
      if (i % 8 == 0)
        b[7] = (i / 8 + 1 < n);
      exp_q.push_back({1'b0, b});
    end
    exp_q.push_back({1'b0, OFFSET_FILL});
    exp_q.push_back({1'b0, PAD_FILL});
    for (int i = 0; i < cl; i++)
      exp_q.push_back({1'b0, pay_data_i + 8'(i)});
    exp_q[$][8] = 1'b1;
    {cap_len_i, hash_i, filter_class_tag_i, ext_count_i} = {cl, h, c, 3'(n)};
    // Start held two edges: the second falls while busy and must be ignored
    start_i = 1'b1;
    repeat (2) @(posedge clk_sys_i);
    #1 start_i = 1'b0;
    for (w = 0; (busy_o !== 1'b0 || sink.q.size() < exp_q.size()) && w < 500; w++)
      @(posedge clk_sys_i);
    if (w == 500)
    begin
      err_total++;
      $display("[FAIL] t=%0t record did not complete", $time);
      stop_test();
    end
    repeat (3) @(posedge clk_sys_i);
    #1 check(9'(sink.q.size()), 9'(exp_q.size()));
    foreach (exp_q[i])
      if (i != 16 + 8 * n)
        check(sink.q[i], exp_q[i]);
    $display("record with %0d blocks and %0d payload bytes done", n, cl);
  endtask
  task test_two_blocks;
    run_rec(2, 16'd3, 4'ha, 12'h5c3);
  endtask
  task test_bare_record;
    run_rec(0, 16'd0, 4'hf, 12'hfff);
  endtask
  task test_full_chain;
    run_rec(EXT_MAX, 16'd5, 4'h0, 12'h801);
  endtask
  initial
  begin
    {reset_n_i, start_i, cap_len_i, hash_i, filter_class_tag_i, ext_count_i} = '0;
    repeat (2) @(posedge clk_sys_i);
    #1 reset_n_i = 1'b1;
    test_two_blocks();
    test_bare_record();
    test_full_chain();
    stop_test();
  end
endmodule
